// File: src/stcd_regs.svh
// constants for the sub-audio tone and code decoder
// assumes the 100 MHz core clock and 8-bit selection values
`ifndef STCD_REGS_SVH
`define STCD_REGS_SVH

`define STCD_SEL_NONE 8'h00
`define STCD_SEL_CODE_LO 8'h01
`define STCD_SEL_CODE_HI 8'h53
`define STCD_SEL_USER_CODE 8'h54
`define STCD_SEL_INV_LO 8'h65
`define STCD_SEL_INV_HI 8'hB7
`define STCD_SEL_INV_USER 8'hB8
`define STCD_INV_OFFSET 8'h64
`define STCD_SEL_CAPTURE 8'hC8
`define STCD_TONE_FIRST 8'hC9
`define STCD_CAPTURE_LAST 8'hEF
`define STCD_TONE_ALLCALL 8'hF0
`define STCD_TONE_USER 8'hFC
`define STCD_TONE_MAINT 8'hFD
`define STCD_TONE_TURNOFF 8'hFE
`define STCD_TONE_INVALID 8'hFF

`define STCD_SETUP_THR_LSB 0
`define STCD_SETUP_THR_MSB 3
`define STCD_SETUP_BW_LSB 4
`define STCD_SETUP_BW_MSB 7
`define STCD_SETUP_LEN24_BIT 11

`define STCD_MAX_ERRORS 5'h03
`define STCD_UPDATE_EVERY 2'h3
`define STCD_CODE_BITS 6'h18

`define STCD_CLK_MHZ 100
`define STCD_TURNOFF_MIN_MS 150

`endif

// File: src/stcd_pkg.sv
// shared types for the sub-audio tone and code decoder
// assumes stcd_regs.svh holds every numeric constant
`default_nettype none
package stcd_pkg;
   typedef enum logic [1:0] {
      STCD_IDLE,
      STCD_TONE,
      STCD_CODE
   } stcd_func_e;
   typedef logic [7:0] stcd_sel_t;
endpackage
`default_nettype wire

// File: src/stcd_code_corr.sv
// sliding correlator for 23/24-bit coded squelch words
// assumes one sliced bit per strobe, already polarity-corrected
`include "stcd_regs.svh"
`default_nettype none
module stcd_code_corr
   import stcd_pkg::*;
#(
   parameter int WORD_BITS = 24
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic len24,
   input wire logic [WORD_BITS-1:0] codeWord,
   input wire logic bitIn,
   input wire logic bitStrobe,
   output logic matchOk,
   output logic matchInverted
);
   logic [WORD_BITS-1:0] shift_q;
   logic [WORD_BITS-1:0] shift_d;
   logic [5:0] fill_q;
   logic [1:0] phase_q;
   logic [WORD_BITS-1:0] window;
   logic [WORD_BITS-1:0] mask;
   logic [4:0] errTrue;
   logic [4:0] errInv;

   function automatic logic [4:0] popCount(input logic [WORD_BITS-1:0] v);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < WORD_BITS; i++) begin
         n = n + {4'h0, v[i]};
      end
      return n;
   endfunction

   // first received bit lands at bit 0, so comparison runs lsb first
   // judged with the bit on this strobe, else a word never lines up;
   // only every 4th alignment is judged, so 23-bit streams hit less often
   always_comb begin
      shift_d = {bitIn, shift_q[WORD_BITS-1:1]};
      window = len24 ? shift_d : {1'b0, shift_d[WORD_BITS-1:1]}; // see R16
      mask = len24 ? {WORD_BITS{1'b1}} : {1'b0, {(WORD_BITS-1){1'b1}}};
      errTrue = popCount((window ^ codeWord) & mask);
      errInv = popCount((window ^ ~codeWord) & mask); // see R14
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shift_q <= '0;
         fill_q <= 6'h00;
      end else if (!enable) begin
         fill_q <= 6'h00;
      end else if (bitStrobe) begin
         shift_q <= shift_d; // see R13
         if (fill_q != `STCD_CODE_BITS) begin
            fill_q <= fill_q + 6'h01;
         end
      end
   end

   // verdict only moves every fourth bit, which damps flicker
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         phase_q <= 2'h0;
         matchOk <= 1'b0;
         matchInverted <= 1'b0;
      end else if (!enable) begin
         phase_q <= 2'h0;
         matchOk <= 1'b0;
         matchInverted <= 1'b0;
      end else if (bitStrobe) begin
         phase_q <= phase_q + 2'h1;
         if (phase_q == `STCD_UPDATE_EVERY) begin // see R17
            if (fill_q < `STCD_CODE_BITS - 6'h01) begin
               matchOk <= 1'b0;
            end else if (errTrue <= `STCD_MAX_ERRORS) begin
               matchOk <= 1'b1;
               matchInverted <= 1'b0;
            end else if (errInv <= `STCD_MAX_ERRORS) begin
               matchOk <= 1'b1;
               matchInverted <= 1'b1;
            end else begin
               matchOk <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: src/stcd_decoder.sv
// receive-side sub-audio tone and coded squelch decoder, top level
// assumes a front end that classifies the sub-audio tone and slices code bits
// Behaviour
// R1: tone detected sets status bit 11
// R2: setup word sets bandwidth/threshold; selection picks tone
// R3: interrupt on tone appear, vanish or change
// R4: own tone shows number, none shows 00
// R5: non-table tone reports FF with interrupts
// R6: other table tone reports 255 unless capturing
// R7: selection 200 captures tones 1 to 39
// R8: capture needs tone enable; transmit outputs silence
// R9: status never reads back 200
// R10: selection 0 scans only all-call tone
// R11: all-call tone always reported when enabled
// R12: 252 user, 253 maintenance, 254 turn-off tone
// R13: accept 23/24-bit NRZ codes, either polarity
// R14: 1-83 true, 101-183 inverted codes match
// R15: cancel input amplifier inversion internally
// R16: compare code bits lsb first
// R17: status bit 10 for three errors, every 4th
// R18: report received code true or inverted value
// R19: after valid code, turn-off tone reports 254
// R20: no-tone and turn-off may both flag
// R21: tone and code detection never run together
// R22: host narrows bandwidth for split tones
// R23: selection byte encodes codes, capture and tones
// R24: mode enables switch functions, selection kept
// R25: masked interrupt stays pending until status read; here a change seen while toneIrqEnable is low never sets irq
`include "stcd_regs.svh"
`default_nettype none
module stcd_decoder
   import stcd_pkg::*;
#(
   parameter int WORD_BITS = 24,
   parameter int TURNOFF_MIN_CYCLES = `STCD_TURNOFF_MIN_MS * `STCD_CLK_MHZ * 1000
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] audioSel,
   input wire logic toneEnable,
   input wire logic codeEnable,
   input wire logic txMode,
   input wire logic [15:0] decoderSetupWord,
   input wire logic [WORD_BITS-1:0] codeWord,
   input wire logic [WORD_BITS-1:0] userCodeWord,
   input wire logic toneIrqEnable,
   input wire logic statusRead,
   input wire logic tonePresent,
   input wire logic toneInTable,
   input wire logic [7:0] toneNum,
   input wire logic slicedBit,
   input wire logic slicedStrobe,
   output logic toneDetected,
   output logic codeDetected,
   output logic [7:0] toneStatus,
   output logic irq,
   output logic [3:0] detBandwidth,
   output logic [3:0] detThreshold,
   output logic [7:0] toneSelect,
   output logic txToneMute,
   output logic len24
);
   stcd_func_e func;
   logic capture;
   logic [7:0] toneValue;
   logic [7:0] codeIndex;
   logic codeSelValid;
   logic userSel;
   logic corrOk;
   logic corrInv;
   logic [7:0] codeValue;
   logic [7:0] status_d;
   logic [31:0] offCount_q;
   logic codeSeen_q;
   logic turnOff_q;
   logic offTone;

   function automatic logic inRange(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   // code wins nothing: tone enable takes priority so both never run
   always_comb begin
      if (toneEnable) begin // see R21, R24
         func = STCD_TONE;
      end else if (codeEnable) begin
         func = STCD_CODE;
      end else begin
         func = STCD_IDLE;
      end
   end

   assign capture = (audioSel == `STCD_SEL_CAPTURE) && (func == STCD_TONE); // see R7, R8

   // tone classification
   always_comb begin
      if (!tonePresent) begin
         toneValue = `STCD_SEL_NONE; // see R4
      end else if (!toneInTable) begin
         toneValue = `STCD_TONE_INVALID; // see R5
      end else if (toneNum == `STCD_TONE_ALLCALL) begin
         toneValue = `STCD_TONE_ALLCALL; // see R11, R10
      end else if (capture && inRange(toneNum, `STCD_TONE_FIRST, `STCD_CAPTURE_LAST)) begin
         toneValue = toneNum; // see R7, R9
      end else if (audioSel != `STCD_SEL_NONE && audioSel != `STCD_SEL_CAPTURE
                   && toneNum == audioSel) begin
         toneValue = toneNum; // see R4, R12
      end else begin
         toneValue = `STCD_TONE_INVALID; // see R6
      end
   end

   // code selection decode, the two forms map to one index
   always_comb begin
      codeSelValid = 1'b1;
      userSel = 1'b0;
      codeIndex = audioSel;
      if (inRange(audioSel, `STCD_SEL_CODE_LO, `STCD_SEL_USER_CODE)) begin // see R23
         userSel = (audioSel == `STCD_SEL_USER_CODE);
      end else if (inRange(audioSel, `STCD_SEL_INV_LO, `STCD_SEL_INV_USER)) begin
         codeIndex = audioSel - `STCD_INV_OFFSET;
         userSel = (audioSel == `STCD_SEL_INV_USER);
      end else begin
         codeSelValid = 1'b0;
      end
   end

   stcd_code_corr #(
      .WORD_BITS(WORD_BITS)
   ) u_corr (
      .core_clk(core_clk),
      .reset(reset),
      .enable(func == STCD_CODE && codeSelValid),
      .len24(decoderSetupWord[`STCD_SETUP_LEN24_BIT]),
      .codeWord(userSel ? userCodeWord : codeWord),
      .bitIn(~slicedBit), // see R15
      .bitStrobe(slicedStrobe),
      .matchOk(corrOk),
      .matchInverted(corrInv)
   );

   assign codeValue = corrInv ? codeIndex + `STCD_INV_OFFSET : codeIndex; // see R18

   // turn-off tone qualified over its minimum length; the tone is not
   // aligned to code words, so a no-code report may precede it
   assign offTone = tonePresent && toneInTable && toneNum == `STCD_TONE_TURNOFF;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         codeSeen_q <= 1'b0;
         offCount_q <= '0;
         turnOff_q <= 1'b0;
      end else if (func != STCD_CODE) begin
         codeSeen_q <= 1'b0;
         offCount_q <= '0;
         turnOff_q <= 1'b0;
      end else begin
         if (corrOk) begin
            codeSeen_q <= 1'b1; // see R19
         end
         if (!offTone || !codeSeen_q) begin
            offCount_q <= '0;
            turnOff_q <= 1'b0;
         end else if (offCount_q == 32'(TURNOFF_MIN_CYCLES - 1)) begin
            turnOff_q <= 1'b1; // see R19, R20
         end else begin
            offCount_q <= offCount_q + 32'h1;
         end
      end
   end

   always_comb begin
      case (func)
         STCD_TONE: status_d = toneValue;
         STCD_CODE: begin
            if (turnOff_q) begin
               status_d = `STCD_TONE_TURNOFF; // see R19
            end else if (corrOk) begin
               status_d = codeValue;
            end else begin
               status_d = `STCD_SEL_NONE; // see R20
            end
         end
         default: status_d = `STCD_SEL_NONE;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         toneStatus <= `STCD_SEL_NONE;
         toneDetected <= 1'b0;
         codeDetected <= 1'b0;
      end else begin
         toneStatus <= status_d;
         toneDetected <= func == STCD_TONE && status_d != `STCD_SEL_NONE
                         && status_d != `STCD_TONE_INVALID; // see R1
         codeDetected <= func == STCD_CODE && corrOk; // see R17
      end
   end

   // pending event: a new change in the read cycle survives the clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else if (status_d != toneStatus && toneIrqEnable) begin
         irq <= 1'b1; // see R3, R5, R19, R25
      end else if (statusRead) begin
         irq <= 1'b0; // see R25
      end
   end

   // front-end steering
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         detBandwidth <= 4'h0;
         detThreshold <= 4'h0;
         toneSelect <= `STCD_SEL_NONE;
         txToneMute <= 1'b0;
         len24 <= 1'b0;
      end else begin
         detBandwidth <= decoderSetupWord[`STCD_SETUP_BW_MSB:`STCD_SETUP_BW_LSB]; // see R2
         detThreshold <= decoderSetupWord[`STCD_SETUP_THR_MSB:`STCD_SETUP_THR_LSB];
         len24 <= decoderSetupWord[`STCD_SETUP_LEN24_BIT];
         if (audioSel == `STCD_SEL_NONE) begin
            toneSelect <= `STCD_TONE_ALLCALL; // see R10
         end else if (audioSel == `STCD_SEL_CAPTURE) begin
            toneSelect <= `STCD_SEL_NONE; // see R7
         end else begin
            toneSelect <= audioSel; // see R2, R12
         end
         txToneMute <= txMode && toneEnable && (audioSel == `STCD_SEL_NONE
                       || audioSel == `STCD_SEL_CAPTURE); // see R8, R10
      end
   end
endmodule
`default_nettype wire

// File: bench/stcd_decoder_checker.sv
// assertions on the ports of the sub-audio decoder
// assumes one clock domain and async active-high reset
`default_nettype none
module stcd_decoder_checker (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] audioSel,
   input wire logic toneEnable,
   input wire logic txMode,
   input wire logic toneIrqEnable,
   input wire logic statusRead,
   input wire logic tonePresent,
   input wire logic toneInTable,
   input wire logic [7:0] toneNum,
   input wire logic toneDetected,
   input wire logic codeDetected,
   input wire logic [7:0] toneStatus,
   input wire logic irq,
   input wire logic txToneMute
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   sequence s_rx;
      toneEnable && !txMode && tonePresent;
   endsequence
   sequence s_own;
      s_rx ##0 toneInTable && toneNum == audioSel && audioSel > 8'hC8 && audioSel < 8'hFF;
   endsequence
   sequence s_gone;
      s_rx ##1 toneEnable && !tonePresent;
   endsequence
   property p_own;
      s_own |=> toneDetected && toneStatus == $past(audioSel);
   endproperty
   a_own: assert property (p_own) else $error("own tone not reported");
   property p_gone;
      s_gone |=> toneStatus == 8'h00 && !toneDetected;
   endproperty
   a_gone: assert property (p_gone) else $error("lost tone not cleared");
   property p_unrec;
      s_rx ##0 !toneInTable |=> toneStatus == 8'hFF;
   endproperty
   a_unrec: assert property (p_unrec) else $error("unknown tone not FF");
   property p_allcall;
      s_rx ##0 toneInTable && toneNum == 8'hF0 |=> toneStatus == 8'hF0;
   endproperty
   a_allcall: assert property (p_allcall) else $error("all-call not reported");
   property p_no200;
      toneStatus != 8'hC8;
   endproperty
   a_no200: assert property (p_no200) else $error("capture value read back");
   property p_irq_set;
      $past(toneIrqEnable) && !$stable(toneStatus) |-> irq;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("status change without irq");
   property p_irq_hold;
      irq && !statusRead |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unread");
   property p_mask;
      !irq && !toneIrqEnable |=> !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("masked irq raised");
   property p_excl;
      toneEnable [*3] |-> !codeDetected;
   endproperty
   a_excl: assert property (p_excl) else $error("code flag with tone on");
   property p_mute;
      txMode && toneEnable && (audioSel == 8'hC8 || audioSel == 8'h00) |=> txToneMute;
   endproperty
   a_mute: assert property (p_mute) else $error("tx tone not muted");
endmodule
bind stcd_decoder stcd_decoder_checker i_chk (.core_clk(core_clk), .reset(reset),
   .audioSel(audioSel), .toneEnable(toneEnable), .txMode(txMode),
   .toneIrqEnable(toneIrqEnable), .statusRead(statusRead), .tonePresent(tonePresent),
   .toneInTable(toneInTable), .toneNum(toneNum), .toneDetected(toneDetected),
   .codeDetected(codeDetected), .toneStatus(toneStatus), .irq(irq),
   .txToneMute(txToneMute));
`default_nettype wire

// File: bench/stcd_front_model.sv
// receiver front end model: tone classifier and code slicer
// assumes tasks are called from the bench, one at a time
`default_nettype none
module stcd_front_model (
   input wire logic core_clk,
   output logic tonePresent,
   output logic toneInTable,
   output logic [7:0] toneNum,
   output logic slicedBit,
   output logic slicedStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tonePresent = 1'b0;
      toneInTable = 1'b0;
      toneNum = 8'h00;
      slicedBit = 1'b0;
      slicedStrobe = 1'b0;
   end
   task automatic set_tone(input logic p, input logic t, input logic [7:0] n);
      @(posedge core_clk);
      tonePresent <= p;
      toneInTable <= t;
      toneNum <= n;
   endtask
   // two whole words so the correlator fills and hits a 4th-bit verdict
   task automatic send_code(input logic [23:0] w, input logic inv);
      for (int i = 0; i < 48; i++) begin
         @(posedge core_clk);
         slicedBit <= ~(w[i % 24] ^ inv); // amp inverts; lsb first
         slicedStrobe <= 1'b1;
         @(posedge core_clk);
         slicedStrobe <= 1'b0;
      end
      @(posedge core_clk);
      slicedBit <= ~slicedBit; // no stale level once idle
   endtask
endmodule
`default_nettype wire

// File: bench/stcd_decoder_tb.sv
// self-checking bench for the sub-audio decoder
// assumes the front end model and checker beside it
`default_nettype none
module stcd_decoder_tb;
   import stcd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TURNOFF_CYC = 20;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] audioSel = 8'h00;
   logic toneEnable = 1'b0;
   logic codeEnable = 1'b0;
   logic txMode = 1'b0;
   logic [15:0] decoderSetupWord = 16'h08A5; // wide band: no split tones sent
   logic [23:0] codeWord = 24'h763813;
   logic [23:0] userCodeWord = 24'h000000;
   logic toneIrqEnable = 1'b1;
   logic statusRead = 1'b0;
   wire logic tonePresent, toneInTable, slicedBit, slicedStrobe;
   wire logic [7:0] toneNum;
   logic toneDetected, codeDetected, irq, txToneMute, len24;
   logic [7:0] toneStatus, toneSelect;
   logic [3:0] detBandwidth, detThreshold;
   int mismatches = 0;
   int num_checks = 0;
   always #5 core_clk = ~core_clk;
   stcd_front_model i_fe (.core_clk(core_clk), .tonePresent(tonePresent),
      .toneInTable(toneInTable), .toneNum(toneNum), .slicedBit(slicedBit),
      .slicedStrobe(slicedStrobe));
   stcd_decoder #(.WORD_BITS(24), .TURNOFF_MIN_CYCLES(TURNOFF_CYC)) i_dut (
      .core_clk(core_clk), .reset(reset), .audioSel(audioSel), .toneEnable(toneEnable),
      .codeEnable(codeEnable), .txMode(txMode), .decoderSetupWord(decoderSetupWord),
      .codeWord(codeWord), .userCodeWord(userCodeWord), .toneIrqEnable(toneIrqEnable),
      .statusRead(statusRead), .tonePresent(tonePresent), .toneInTable(toneInTable),
      .toneNum(toneNum), .slicedBit(slicedBit), .slicedStrobe(slicedStrobe),
      .toneDetected(toneDetected), .codeDetected(codeDetected), .toneStatus(toneStatus),
      .irq(irq), .detBandwidth(detBandwidth), .detThreshold(detThreshold),
      .toneSelect(toneSelect), .txToneMute(txToneMute), .len24(len24));
   task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic cfg(input logic [7:0] s, input logic te, input logic ce, input logic tx);
      @(posedge core_clk);
      audioSel <= s;
      toneEnable <= te;
      codeEnable <= ce;
      txMode <= tx;
      tick(2);
   endtask
   task automatic rd;
      @(posedge core_clk);
      statusRead <= 1'b1;
      @(posedge core_clk);
      statusRead <= 1'b0;
      tick(1);
   endtask
   task automatic tone(input logic p, input logic t, input logic [7:0] n);
      i_fe.set_tone(p, t, n);
      tick(2);
   endtask
   task automatic t_own_tone;
      cfg(8'hD0, 1'b1, 1'b0, 1'b0);
      chk8(8'hD0, toneSelect);
      chk8(8'hA5, {detBandwidth, detThreshold});
      tone(1'b1, 1'b1, 8'hD0);
      chk8(8'hD0, toneStatus);
      chk1(1'b1, toneDetected);
      chk1(1'b1, irq);
      rd();
      chk1(1'b0, irq);
      tone(1'b0, 1'b1, 8'hD0);
      chk8(8'h00, toneStatus);
      chk1(1'b1, irq);
      rd();
   endtask
   task automatic t_other_tones;
      tone(1'b1, 1'b0, 8'h33);
      chk8(8'hFF, toneStatus);
      chk1(1'b1, irq);
      rd();
      tone(1'b1, 1'b1, 8'hD5);
      chk8(8'hFF, toneStatus);
      tone(1'b1, 1'b1, 8'hF0);
      chk8(8'hF0, toneStatus);
      tone(1'b0, 1'b0, 8'h00);
      rd();
      @(posedge core_clk);
      toneIrqEnable <= 1'b0;
      tone(1'b1, 1'b1, 8'hD0);
      chk1(1'b0, irq);
      tone(1'b0, 1'b1, 8'hD0);
      chk1(1'b0, irq);
      @(posedge core_clk);
      toneIrqEnable <= 1'b1;
   endtask
   task automatic t_capture;
      cfg(8'hC8, 1'b1, 1'b0, 1'b0);
      chk8(8'h00, toneSelect);
      tone(1'b1, 1'b1, 8'hD5);
      chk8(8'hD5, toneStatus);
      tone(1'b0, 1'b1, 8'hD5);
      cfg(8'hC8, 1'b1, 1'b0, 1'b1);
      chk1(1'b1, txToneMute);
      cfg(8'h00, 1'b1, 1'b0, 1'b1);
      chk1(1'b1, txToneMute);
      cfg(8'h00, 1'b1, 1'b0, 1'b0);
      chk8(8'hF0, toneSelect);
      tone(1'b1, 1'b1, 8'hD0);
      chk8(8'hFF, toneStatus);
      tone(1'b0, 1'b1, 8'hD0);
      rd();
   endtask
   task automatic t_code;
      cfg(8'h01, 1'b0, 1'b1, 1'b0);
      chk1(1'b1, len24);
      i_fe.send_code(codeWord, 1'b0);
      tick(4);
      chk1(1'b1, codeDetected);
      chk8(8'h01, toneStatus);
      i_fe.send_code(codeWord, 1'b1);
      tick(4);
      chk1(1'b1, codeDetected);
      chk8(8'h65, toneStatus);
      i_fe.send_code(codeWord ^ 24'h000007, 1'b0);
      tick(4);
      chk1(1'b1, codeDetected);
      i_fe.send_code(codeWord ^ 24'h00000F, 1'b0);
      tick(4);
      chk1(1'b0, codeDetected);
      i_fe.send_code(codeWord, 1'b0);
      tick(4);
      rd();
      tone(1'b1, 1'b1, 8'hFE);
      tick(TURNOFF_CYC + 8);
      chk8(8'hFE, toneStatus);
      chk1(1'b1, irq);
      tone(1'b0, 1'b0, 8'h00);
      cfg(8'h01, 1'b1, 1'b1, 1'b0);
      i_fe.send_code(codeWord, 1'b0);
      tick(4);
      chk1(1'b0, codeDetected);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      tick(2);
      t_own_tone();
      t_other_tones();
      t_capture();
      t_code();
      complete_run();
   end
endmodule
`default_nettype wire
